// [hw/eeprom_link_pkg.sv]
package eeprom_link_pkg;
  // array shape
  localparam int ADDR_W = 18;
  localparam int BYTE_W = 8;
  localparam int MEM_DEPTH = 262144;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // device address byte layout
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic CHIP_SEL = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  // bit counting within a byte
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // byte position within a device transfer
  localparam logic [1:0] IDX_DEV = 2'h0;
  localparam logic [1:0] IDX_HI = 2'h1;
  localparam logic [1:0] IDX_LO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;
  // byte steps of the master sequence
  localparam logic [2:0] STEP_DEV_WR = 3'h0;
  localparam logic [2:0] STEP_HI = 3'h1;
  localparam logic [2:0] STEP_LO = 3'h2;
  localparam logic [2:0] STEP_DEV_RD = 3'h3;
  localparam logic [2:0] STEP_DATA = 3'h4;
  // link timing: master makes a 1008 ns clock (1000 ns rounded up) from four quarters of 63 cycles
  localparam int MCLK_PERIOD_NS = 4;
  localparam int SCL_PERIOD_NS = 1000;
  localparam int QUARTER_CYCLES = (SCL_PERIOD_NS / 4 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [9:0] QUARTER_LAST = 10'(QUARTER_CYCLES - 1);
  localparam logic [1:0] Q_LAST = 2'h3;

  typedef enum logic [4:0] {
    DEV_IDLE = 5'b00001,
    DEV_RECV = 5'b00010,
    DEV_ACK = 5'b00100,
    DEV_SEND = 5'b01000,
    DEV_MACK = 5'b10000
  } dev_state_type;

  typedef enum logic [3:0] {
    MST_IDLE = 4'b0001,
    MST_START = 4'b0010,
    MST_BYTE = 4'b0100,
    MST_STOP = 4'b1000
  } mst_state_type;
endpackage

// [hw/eeprom_link_if.sv]
`timescale 1ns/10ps
interface eeprom_link_if;
  logic mst_scl_out;
  logic mst_scl_oe_n;
  logic mst_sda_out;
  logic mst_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // open-drain wires: a low wins, otherwise the pull-up holds the line high
  assign scl = mst_scl_oe_n | mst_scl_out;
  assign sda = (mst_sda_oe_n | mst_sda_out) & (dev_sda_oe_n | dev_sda_out);

  modport device_mp (
    input scl,
    input sda,
    output dev_sda_out,
    output dev_sda_oe_n
  );

  modport master_mp (
    input sda,
    output mst_scl_out,
    output mst_scl_oe_n,
    output mst_sda_out,
    output mst_sda_oe_n
  );
endinterface

// [hw/eeprom_read_device.sv]
`timescale 1ns/10ps
// Overview of operation
// - read bit one in device byte requests read
// - counter holds last accessed address plus one
// - counter wraps from last byte to first
// - valid read address: ack, then send byte
// - master nack on ninth clock ends read
// - after nack master sends stop or start
// - current read ignores upper address bits sent
// - no stop after dummy write, no write
// - repeated start read keeps dummy-write upper bits
// - random read ends with nack then stop
// - each master ack increments counter, next byte
// - sequential read wraps to array start
// - sequential read ends with nack then stop
// - unprogrammed locations read as all ones
// - address is two upper bits plus two bytes
// - no acknowledge while write cycle busy
module eeprom_read_device
  import eeprom_link_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // link
  eeprom_link_if.device_mp link,
  // write side hooks
  input wire logic busy_in,
  input wire logic prog_en_in,
  input wire logic [ADDR_W-1:0] prog_addr_in,
  input wire logic [BYTE_W-1:0] prog_data_in,
  output logic write_start_out,
  output logic [ADDR_W-1:0] addr_out
);

  logic [BYTE_W-1:0] mem [MEM_DEPTH];
  logic [BYTE_W-1:0] mem_q;

  // erased array content as delivered
  initial begin
    for (int i = 0; i < MEM_DEPTH; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (prog_en_in) begin
      mem[prog_addr_in] <= prog_data_in;
    end
  end

  // pin synchronisers and edge history
  logic scl_meta_q, scl_sync_q, scl_prev_q;
  logic sda_meta_q, sda_sync_q, sda_prev_q;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_meta_q <= link.scl;
      scl_sync_q <= scl_meta_q;
      scl_prev_q <= scl_sync_q;
      sda_meta_q <= link.sda;
      sda_sync_q <= sda_meta_q;
      sda_prev_q <= sda_sync_q;
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_rise = scl_sync_q & ~scl_prev_q;
  assign scl_fall = ~scl_sync_q & scl_prev_q;
  assign start_seen = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
  assign stop_seen = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;

  dev_state_type state_q, state_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] idx_q, idx_d;
  logic [BYTE_W-1:0] shift_q, shift_d;
  logic [BYTE_W-1:0] hi_q, hi_d;
  logic [1:0] top_q, top_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic rw_q, rw_d;
  logic wr_pend_q, wr_pend_d;
  logic sda_oe_n_q, sda_oe_n_d;
  logic wstart_q, wstart_d;

  // registered read; the address settles long before the link needs the byte
  always_ff @(posedge mclk_in) begin
    mem_q <= mem[addr_q];
  end

  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    idx_d = idx_q;
    shift_d = shift_q;
    hi_d = hi_q;
    top_d = top_q;
    addr_d = addr_q;
    rw_d = rw_q;
    wr_pend_d = wr_pend_q;
    sda_oe_n_d = sda_oe_n_q;
    wstart_d = 1'b0;
    if (stop_seen) begin
      // only a stop after written data starts a write cycle
      wstart_d = wr_pend_q;
      wr_pend_d = 1'b0;
      sda_oe_n_d = 1'b1;
      state_d = DEV_IDLE;
    end else if (start_seen) begin
      // a repeated start drops any pending write
      wr_pend_d = 1'b0;
      sda_oe_n_d = 1'b1;
      bit_d = '0;
      idx_d = IDX_DEV;
      state_d = DEV_RECV;
    end else begin
      unique case (state_q)
        DEV_IDLE: begin
          sda_oe_n_d = 1'b1;
        end
        DEV_RECV: begin
          if (scl_rise) begin
            shift_d = {shift_q[BYTE_W-2:0], sda_sync_q};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == BIT_ACK) begin
            bit_d = '0;
            sda_oe_n_d = 1'b0;
            state_d = DEV_ACK;
            unique case (idx_q)
              IDX_DEV: begin
                if (shift_q[7:3] != {DEV_TYPE, CHIP_SEL} || busy_in) begin
                  sda_oe_n_d = 1'b1;
                  state_d = DEV_IDLE;
                end
                rw_d = shift_q[0];
                top_d = shift_q[2:1];
              end
              IDX_HI: begin
                hi_d = shift_q;
              end
              IDX_LO: begin
                // upper bits only count when a word address follows
                addr_d = {top_q, hi_q, shift_q};
              end
              IDX_DATA: begin
                wr_pend_d = 1'b1;
              end
            endcase
            if (idx_q != IDX_DATA) begin
              idx_d = idx_q + 2'h1;
            end
          end
        end
        DEV_ACK: begin
          if (scl_fall) begin
            sda_oe_n_d = 1'b1;
            if (rw_q == RW_READ) begin
              // send from the counter as it stands, upper bits untouched
              shift_d = mem_q;
              sda_oe_n_d = mem_q[BYTE_W-1];
              state_d = DEV_SEND;
            end else begin
              state_d = DEV_RECV;
            end
          end
        end
        DEV_SEND: begin
          if (scl_fall) begin
            if (bit_q == BIT_LAST) begin
              sda_oe_n_d = 1'b1;
              bit_d = '0;
              state_d = DEV_MACK;
            end else begin
              shift_d = {shift_q[BYTE_W-2:0], 1'b0};
              sda_oe_n_d = shift_q[BYTE_W-2];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        DEV_MACK: begin
          if (scl_rise) begin
            // natural overflow of the counter wraps to address zero
            addr_d = addr_q + 18'h00001;
            if (sda_sync_q) begin
              state_d = DEV_IDLE;
            end else begin
              bit_d = BIT_ACK;
            end
          end else if (scl_fall && bit_q == BIT_ACK) begin
            shift_d = mem_q;
            sda_oe_n_d = mem_q[BYTE_W-1];
            bit_d = '0;
            state_d = DEV_SEND;
          end
        end
        default: begin
          sda_oe_n_d = 1'b1;
          state_d = DEV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= DEV_IDLE;
      bit_q <= '0;
      idx_q <= IDX_DEV;
      shift_q <= '0;
      hi_q <= '0;
      top_q <= '0;
      addr_q <= '0;
      rw_q <= RW_WRITE;
      wr_pend_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      wstart_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      idx_q <= idx_d;
      shift_q <= shift_d;
      hi_q <= hi_d;
      top_q <= top_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      wr_pend_q <= wr_pend_d;
      sda_oe_n_q <= sda_oe_n_d;
      wstart_q <= wstart_d;
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe_n = sda_oe_n_q;
  assign write_start_out = wstart_q;
  assign addr_out = addr_q;

endmodule

// [hw/eeprom_read_master.sv]
`timescale 1ns/10ps
module eeprom_read_master
  import eeprom_link_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // link
  eeprom_link_if.master_mp link,
  // request
  input wire logic req_in,
  input wire logic random_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [BYTE_W-1:0] count_in,
  // answer
  output logic busy_out,
  output logic [BYTE_W-1:0] data_out,
  output logic valid_out,
  output logic done_out,
  output logic nack_out
);

  logic sda_meta_q, sda_sync_q;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
    end else begin
      sda_meta_q <= link.sda;
      sda_sync_q <= sda_meta_q;
    end
  end

  mst_state_type state_q, state_d;
  logic [9:0] div_q, div_d;
  logic [1:0] q_q, q_d;
  logic [3:0] bit_q, bit_d;
  logic [2:0] step_q, step_d;
  logic [BYTE_W-1:0] shift_q, shift_d, left_q, left_d, data_q, data_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic rx_q, rx_d, scl_q, scl_d, sda_q, sda_d;
  logic valid_q, valid_d, done_q, done_d, nack_q, nack_d;
  logic tick;
  logic [1:0] nq;

  assign tick = (div_q == QUARTER_LAST);
  assign nq = q_q + 2'h1;

  always_comb begin
    state_d = state_q;
    div_d = tick ? '0 : div_q + 10'h001;
    q_d = tick ? nq : q_q;
    bit_d = bit_q;
    step_d = step_q;
    shift_d = shift_q;
    left_d = left_q;
    data_d = data_q;
    addr_d = addr_q;
    rx_d = rx_q;
    scl_d = scl_q;
    sda_d = sda_q;
    valid_d = 1'b0;
    done_d = 1'b0;
    nack_d = nack_q;
    unique case (state_q)
      MST_IDLE: begin
        div_d = '0;
        q_d = '0;
        if (req_in) begin
          addr_d = addr_in;
          left_d = (count_in == '0) ? '0 : count_in - 8'h01;
          nack_d = 1'b0;
          rx_d = 1'b0;
          step_d = random_in ? STEP_DEV_WR : STEP_DEV_RD;
          shift_d = {DEV_TYPE, CHIP_SEL, addr_in[17:16], random_in ? RW_WRITE : RW_READ};
          state_d = MST_START;
        end
      end
      MST_START: begin
        if (tick) begin
          unique case (nq)
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b0;
            2'h3: sda_d = 1'b0;
            2'h0: begin
              scl_d = 1'b0;
              bit_d = '0;
              state_d = MST_BYTE;
            end
          endcase
        end
        if (tick && q_q == 2'h0) begin
          sda_d = 1'b1;
        end
      end
      MST_BYTE: begin
        if (tick) begin
          unique case (nq)
            2'h1: begin
              if (bit_q != BIT_ACK) begin
                sda_d = rx_q ? 1'b1 : shift_q[BYTE_W-1];
              end else begin
                // ack every wanted byte but the last
                sda_d = rx_q ? (left_q == '0) : 1'b1;
              end
            end
            2'h2: scl_d = 1'b1;
            2'h3: begin
              if (bit_q != BIT_ACK) begin
                shift_d = {shift_q[BYTE_W-2:0], rx_q ? sda_sync_q : 1'b0};
              end else if (rx_q) begin
                data_d = shift_q;
                valid_d = 1'b1;
              end else if (sda_sync_q) begin
                nack_d = 1'b1;
              end
            end
            2'h0: begin
              scl_d = 1'b0;
              bit_d = bit_q + 4'h1;
              if (bit_q == BIT_ACK) begin
                bit_d = '0;
                unique case (step_q)
                  STEP_DEV_WR: shift_d = addr_q[15:8];
                  STEP_HI: shift_d = addr_q[7:0];
                  STEP_LO: shift_d = {DEV_TYPE, CHIP_SEL, addr_q[17:16], RW_READ};
                  STEP_DEV_RD: rx_d = 1'b1;
                  default: left_d = left_q - 8'h01;
                endcase
                if (step_q != STEP_DATA) begin
                  step_d = step_q + 3'h1;
                end
                // repeated start instead of stop after the word address
                if (step_q == STEP_LO && !nack_q) begin
                  state_d = MST_START;
                end
                if (nack_q || (step_q == STEP_DATA && left_q == '0)) begin
                  state_d = MST_STOP;
                end
              end
            end
          endcase
        end
      end
      MST_STOP: begin
        if (tick) begin
          unique case (nq)
            2'h1: sda_d = 1'b0;
            2'h2: scl_d = 1'b1;
            2'h3: sda_d = 1'b1;
            2'h0: begin
              done_d = 1'b1;
              state_d = MST_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= MST_IDLE;
      div_q <= '0;
      q_q <= '0;
      bit_q <= '0;
      step_q <= STEP_DEV_WR;
      shift_q <= '0;
      left_q <= '0;
      data_q <= '0;
      addr_q <= '0;
      rx_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      valid_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      q_q <= q_d;
      bit_q <= bit_d;
      step_q <= step_d;
      shift_q <= shift_d;
      left_q <= left_d;
      data_q <= data_d;
      addr_q <= addr_d;
      rx_q <= rx_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      valid_q <= valid_d;
      done_q <= done_d;
      nack_q <= nack_d;
    end
  end

  // open drain: only ever pull low
  assign link.mst_scl_out = 1'b0;
  assign link.mst_scl_oe_n = scl_q;
  assign link.mst_sda_out = 1'b0;
  assign link.mst_sda_oe_n = sda_q;
  assign busy_out = (state_q != MST_IDLE);
  assign data_out = data_q;
  assign valid_out = valid_q;
  assign done_out = done_q;
  assign nack_out = nack_q;

endmodule

// [test/eeprom_link_monitor.sv]
`timescale 1ns/10ps
module eeprom_link_monitor
  import eeprom_link_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // write cycle state
  input wire logic busy_in,
  // link
  input wire logic mst_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, rd_q, rd_d, idle_q, idle_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic rise, start, stop, nack;

  // decoded straight from the resolved wires, ahead of the synchronisers at either end
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  assign nack = rise && rd_q && byte_q != IDX_DEV && bit_q == BIT_ACK && sda;

  always_comb begin
    bit_d = bit_q;
    byte_d = byte_q;
    rd_d = rd_q;
    idle_d = idle_q;
    if (start || stop) begin
      bit_d = 4'h0;
      byte_d = IDX_DEV;
      rd_d = 1'b0;
    end else if (rise) begin
      bit_d = (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
      if (bit_q == BIT_ACK && byte_q != IDX_DATA) begin
        byte_d = byte_q + 2'h1;
      end
      if (bit_q == BIT_LAST && byte_q == IDX_DEV) begin
        rd_d = sda;
      end
      // an unanswered ack slot ends the read; the stop after it drives data
      if (bit_q == BIT_ACK && sda) begin
        rd_d = 1'b0;
      end
    end
    if (nack) begin
      idle_d = 1'b1;
    end
    if (start) begin
      idle_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rd_q <= 1'b0;
      idle_q <= 1'b0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      rd_q <= rd_d;
      idle_q <= idle_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_close;
    ##[1:600] (stop || start);
  endsequence

  sequence s_restart;
    (!stop) throughout (1'b1 ##[1:600] start);
  endsequence

  a_ack_dev_byte: assert property (
    rise && bit_q == BIT_ACK && byte_q == IDX_DEV && !busy_in |-> !dev_sda_oe_n)
    else $error("device address byte not acknowledged");
  a_busy_no_ack: assert property (
    rise && bit_q == BIT_ACK && byte_q == IDX_DEV && busy_in |-> dev_sda_oe_n)
    else $error("device acknowledged while write cycle busy");
  a_master_lets_go: assert property (
    rise && rd_q && byte_q != IDX_DEV && bit_q != BIT_ACK |-> mst_sda_oe_n)
    else $error("master drives data line during read data bit");
  a_ack_slot_free: assert property (
    rise && rd_q && byte_q != IDX_DEV && bit_q == BIT_ACK |-> dev_sda_oe_n)
    else $error("device drives master acknowledge slot");
  a_nack_standby: assert property (
    idle_q |-> dev_sda_oe_n)
    else $error("device drives data line after read was ended");
  a_end_after_nack: assert property (
    nack |-> s_close)
    else $error("no stop or start after master nack");
  a_restart_no_stop: assert property (
    rise && !rd_q && byte_q == IDX_LO && bit_q == BIT_ACK && !sda |-> s_restart)
    else $error("dummy write not followed by repeated start");
  a_dev_steady_high: assert property (
    scl && $past(scl) |-> $stable(dev_sda_oe_n))
    else $error("device changed data line while clock high");
  a_dev_edge_delay: assert property (
    $changed(dev_sda_oe_n) |-> !scl && ($past(scl, 4) || $past(scl, 5) || $past(scl, 6)))
    else $error("device data change not just after clock fall");
endmodule

// [test/serial_eeprom_read_sequencer_tb_top.sv]
`timescale 1ns/10ps
module serial_eeprom_read_sequencer_tb_top;
  import eeprom_link_pkg::*;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic busy_in = 1'b0;
  logic prog_en_in = 1'b0;
  logic [ADDR_W-1:0] prog_addr_in = '0;
  logic [BYTE_W-1:0] prog_data_in = '0;
  logic req_in = 1'b0;
  logic random_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [BYTE_W-1:0] count_in = '0;
  logic write_start_out, busy_out, valid_out, done_out, nack_out;
  logic [ADDR_W-1:0] addr_out;
  logic [BYTE_W-1:0] data_out;
  logic [BYTE_W-1:0] got[$];
  int errors = 0;
  int n_tests = 0;
  int n_wstart = 0;

  eeprom_link_if link();

  always #2 mclk_in = ~mclk_in;

  eeprom_read_device i_eeprom_read_device (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .link(link), .busy_in(busy_in),
    .prog_en_in(prog_en_in), .prog_addr_in(prog_addr_in), .prog_data_in(prog_data_in),
    .write_start_out(write_start_out), .addr_out(addr_out));

  eeprom_read_master i_eeprom_read_master (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .link(link), .req_in(req_in),
    .random_in(random_in), .addr_in(addr_in), .count_in(count_in), .busy_out(busy_out),
    .data_out(data_out), .valid_out(valid_out), .done_out(done_out), .nack_out(nack_out));

  eeprom_link_monitor i_eeprom_link_monitor (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .busy_in(busy_in),
    .mst_sda_oe_n(link.mst_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n),
    .scl(link.scl), .sda(link.sda));

  // registered outputs are sampled mid-cycle, away from the edge that launches them
  always @(negedge mclk_in) begin
    if (valid_out === 1'b1)
      got.push_back(data_out);
    if (write_start_out === 1'b1)
      n_wstart++;
  end

  task automatic check(input logic [ADDR_W-1:0] g, input logic [ADDR_W-1:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_bytes(input logic [BYTE_W-1:0] e[$]);
    check(ADDR_W'(got.size()), ADDR_W'(e.size()));
    foreach (e[i])
      check(ADDR_W'(got[i]), ADDR_W'(e[i]));
  endtask

  // backdoor array load, one cycle per byte
  task automatic prog(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
    @(negedge mclk_in);
    prog_addr_in = a;
    prog_data_in = d;
    prog_en_in = 1'b1;
    @(negedge mclk_in);
    prog_en_in = 1'b0;
  endtask

  task automatic rd(input logic rnd, input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] n);
    got.delete();
    @(negedge mclk_in);
    random_in = rnd;
    addr_in = a;
    count_in = n;
    req_in = 1'b1;
    @(negedge mclk_in);
    req_in = 1'b0;
    check(ADDR_W'(busy_out), 18'h00001);
    while (done_out !== 1'b1)
      @(negedge mclk_in);
    @(negedge mclk_in);
    check(ADDR_W'(busy_out), '0);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in);
    resetn_in = 1'b1;
    check(addr_out, '0);
    rd(1'b0, 18'h0, 8'h1);
    check_bytes('{ERASED_BYTE});
    check(addr_out, 18'h00001);
    prog(18'h12345, 8'h5a);
    prog(18'h12346, 8'ha5);
    rd(1'b1, 18'h12345, 8'h2);
    check_bytes('{8'h5a, 8'ha5});
    check(addr_out, 18'h12347);
    prog(18'h3ffff, 8'h3c);
    prog(18'h00000, 8'hc3);
    rd(1'b1, 18'h3ffff, 8'h3);
    check_bytes('{8'h3c, 8'hc3, ERASED_BYTE});
    check(addr_out, 18'h00002);
    prog(18'h00002, 8'h77);
    // upper bits of the device byte differ from the counter and must not win
    rd(1'b0, 18'h30000, 8'h1);
    check_bytes('{8'h77});
    check(addr_out, 18'h00003);
    busy_in = 1'b1;
    rd(1'b0, 18'h0, 8'h1);
    check(ADDR_W'(nack_out), 18'h00001);
    check(ADDR_W'(got.size()), '0);
    check(addr_out, 18'h00003);
    busy_in = 1'b0;
    rd(1'b0, 18'h0, 8'h1);
    check_bytes('{ERASED_BYTE});
    check(ADDR_W'(nack_out), '0);
    check(addr_out, 18'h00004);
    check(ADDR_W'(n_wstart), '0);
    report_and_stop();
  end

  // the whole sequence needs about 50000 cycles
  initial begin
    repeat (80000) @(posedge mclk_in);
    errors++;
    $display("wrong value at %0t: run did not finish in time", $time);
    report_and_stop();
  end
endmodule
